// ===== verilog/tx_pcs_serializer_encoder.v
`include "tx_pcs_consts.vh"

module tx_fifo #(
  parameter WIDTH = 44,
  parameter DEPTH = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Handshakes; no write accepted during reset
  assign in_ready  = !rst && (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // tx_fifo

module tx_pcs_serializer_encoder (
  input  wire                   CLK,
  input  wire                   RESET,
  input  wire [`DATA_W-1:0]     TX_PARALLEL_DATA,
  input  wire [`K_W-1:0]        TX_DATAK,
  input  wire                   TX_IN_VALID,
  output wire                   TX_IN_READY,
  input  wire [1:0]             CFG_MODE,
  input  wire                   DOUBLE_WIDTH,
  input  wire                   SYMBOL10,
  input  wire                   USE_SERIALIZER,
  input  wire                   USE_ENCODER,
  input  wire [1:0]             TX_FORCEDISP,
  input  wire [1:0]             TX_DISPVAL,
  input  wire [`SLIP_SEL_W-1:0] TX_SLIP_SEL,
  output reg  [`HALF_W-1:0]     TX_PMA_DATA,
  output reg                    TX_PMA_VALID,
  output wire                   SYNC_DONE
);

  // Picks one half of a fabric word with its control flags
  function [21:0] pick_half;
    input [`DATA_W-1:0] w;
    input [`K_W-1:0]    k;
    input               dw;
    input               s10;
    input               hi;
    begin
      case ({dw, s10})
        2'h0:    pick_half = hi ? {1'b0, k[1], 12'h000, w[15:8]}
                                : {1'b0, k[0], 12'h000, w[7:0]};
        2'h1:    pick_half = hi ? {1'b0, k[1], 10'h000, w[19:10]}
                                : {1'b0, k[0], 10'h000, w[9:0]};
        2'h2:    pick_half = hi ? {k[3:2], 4'h0, w[31:16]}
                                : {k[1:0], 4'h0, w[15:0]};
        default: pick_half = hi ? {k[3:2], w[39:20]}
                                : {k[1:0], w[19:0]};
      endcase
    end
  endfunction

  // One byte to one code group; result is {rd_out, code}
  function [10:0] enc8b10b;
    input [7:0] d;
    input       k;
    input       rd;
    reg [5:0]   s6;
    reg [3:0]   s4;
    reg [9:0]   s;
    reg [2:0]   n6;
    reg [2:0]   n4;
    reg         r;
    reg         alt;
    integer     i;
    begin
      case (d[4:0])
        5'h00: s6 = 6'h27;  5'h01: s6 = 6'h1D;  5'h02: s6 = 6'h2D;
        5'h03: s6 = 6'h31;  5'h04: s6 = 6'h35;  5'h05: s6 = 6'h29;
        5'h06: s6 = 6'h19;  5'h07: s6 = 6'h38;  5'h08: s6 = 6'h39;
        5'h09: s6 = 6'h25;  5'h0A: s6 = 6'h15;  5'h0B: s6 = 6'h34;
        5'h0C: s6 = 6'h0D;  5'h0D: s6 = 6'h2C;  5'h0E: s6 = 6'h1C;
        5'h0F: s6 = 6'h17;  5'h10: s6 = 6'h1B;  5'h11: s6 = 6'h23;
        5'h12: s6 = 6'h13;  5'h13: s6 = 6'h32;  5'h14: s6 = 6'h0B;
        5'h15: s6 = 6'h2A;  5'h16: s6 = 6'h1A;  5'h17: s6 = 6'h3A;
        5'h18: s6 = 6'h33;  5'h19: s6 = 6'h26;  5'h1A: s6 = 6'h16;
        5'h1B: s6 = 6'h36;  5'h1C: s6 = 6'h0E;  5'h1D: s6 = 6'h2E;
        5'h1E: s6 = 6'h1E;  default: s6 = 6'h2B;
      endcase
      if (k && d[4:0] == 5'h1C) begin
        s6 = 6'h0F;
      end
      r  = rd;
      n6 = {2'h0, s6[0]} + {2'h0, s6[1]} + {2'h0, s6[2]}
         + {2'h0, s6[3]} + {2'h0, s6[4]} + {2'h0, s6[5]};
      if (r && (n6 != 3'h3 || d[4:0] == 5'h07)) begin
        s6 = ~s6;
      end
      if (n6 != 3'h3) begin
        r = ~r;
      end
      alt = k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
                         d[4:0] == 5'h14)) ||
                 (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D ||
                        d[4:0] == 5'h0E));
      case ({k, d[7:5]})
        4'h0:    s4 = 4'hB;  4'h1: s4 = 4'h9;  4'h2: s4 = 4'h5;
        4'h3:    s4 = 4'hC;  4'h4: s4 = 4'hD;  4'h5: s4 = 4'hA;
        4'h6:    s4 = 4'h6;  4'h7: s4 = alt ? 4'h7 : 4'hE;
        4'h8:    s4 = 4'hB;  4'h9: s4 = 4'h6;  4'hA: s4 = 4'hA;
        4'hB:    s4 = 4'hC;  4'hC: s4 = 4'hD;  4'hD: s4 = 4'h5;
        4'hE:    s4 = 4'h9;  default: s4 = 4'h7;
      endcase
      n4 = {2'h0, s4[0]} + {2'h0, s4[1]} + {2'h0, s4[2]} + {2'h0, s4[3]};
      if (r && (k || n4 != 3'h2 || d[7:5] == 3'h3)) begin
        s4 = ~s4;
      end
      if (n4 != 3'h2) begin
        r = ~r;
      end
      s = {s6, s4};
      for (i = 0; i < 10; i = i + 1) begin
        enc8b10b[i] = s[9-i];
      end
      enc8b10b[10] = r;
    end
  endfunction

  wire [`DATA_W+`K_W-1:0] fifo_data;
  wire                    fifo_valid;
  wire                    fifo_ready;
  wire                    enc_on;
  wire                    slip_on;
  wire                    hi_sel;
  wire [21:0]             half;
  wire [10:0]             e0;
  wire [10:0]             e1;
  wire                    rd0_in;
  wire                    rd1_in;
  wire                    syncing;
  wire [7:0]              b0;
  wire [7:0]              b1;
  wire                    k0;
  wire                    k1;
  wire [`HALF_W-1:0]      rst_pat;
  wire [5:0]              pma_w;
  wire [5:0]              slip_n;
  wire [39:0]             comb;
  reg                     phase_q;
  reg                     rd_q;
  reg  [1:0]              sync_cnt_q;
  reg  [`HALF_W-1:0]      enc_q;
  reg                     valid_a_q;
  reg  [`HALF_W-1:0]      prev_q;
  reg  [`HALF_W-1:0]      enc_d;
  reg                     rd_d;
  reg                     take_half;

  // Input buffer; its ready is the fabric back-pressure
  tx_fifo #(
    .WIDTH (`DATA_W + `K_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RESET),
    .in_valid  (TX_IN_VALID),
    .in_ready  (TX_IN_READY),
    .in_data   ({TX_DATAK, TX_PARALLEL_DATA}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // Mode qualification
  assign enc_on  = USE_ENCODER && (CFG_MODE == `CFG_PCIE);
  assign slip_on = (CFG_MODE == `CFG_10G);
  assign syncing = enc_on && (sync_cnt_q != `SYNC_COUNT);
  assign SYNC_DONE = !syncing;

  // Byte serializer: low half, then high half of each word
  assign hi_sel     = USE_SERIALIZER && phase_q;
  assign fifo_ready = !syncing && (!USE_SERIALIZER || phase_q);
  assign half = pick_half(fifo_data[`DATA_W-1:0],
                          fifo_data[`DATA_W+`K_W-1:`DATA_W],
                          DOUBLE_WIDTH, SYMBOL10 && !enc_on, hi_sel);

  // Sync groups replace user bytes until three words of them were sent
  assign b0 = syncing ? `K285_BYTE : half[7:0];
  assign b1 = syncing ? `K285_BYTE : half[15:8];
  assign k0 = syncing ? 1'b1 : half[20];
  assign k1 = syncing ? 1'b1 : half[21];

  // Cascaded encoders, disparity chained low to high
  assign rd0_in = (TX_FORCEDISP[0] && !syncing) ? TX_DISPVAL[0] : rd_q;
  assign e0     = enc8b10b(b0, k0, rd0_in);
  assign rd1_in = (TX_FORCEDISP[1] && !syncing) ? TX_DISPVAL[1]
                                                : e0[10];
  assign e1     = enc8b10b(b1, k1, rd1_in);

  // Pattern held during reset
  assign rst_pat = !enc_on ? {`HALF_W{1'b0}} :
                   DOUBLE_WIDTH ? {`K285_POS, `K285_NEG}
                                : {10'h000, `K285_NEG};

  // Next word of the coding stage
  always @* begin
    take_half = fifo_valid && !syncing;
    rd_d      = rd_q;
    enc_d     = half[`HALF_W-1:0];
    if (enc_on) begin
      rd_d  = DOUBLE_WIDTH ? e1[10] : e0[10];
      enc_d = DOUBLE_WIDTH ? {e1[9:0], e0[9:0]}
                           : {10'h000, e0[9:0]};
    end
  end

  // Coding stage registers
  always @(posedge CLK) begin
    if (RESET) begin
      rd_q       <= `RD_NEG;
      sync_cnt_q <= 2'h0;
      phase_q    <= 1'b0;
      enc_q      <= rst_pat;
      valid_a_q  <= enc_on;
    end else if (syncing) begin
      rd_q       <= rd_d;
      sync_cnt_q <= sync_cnt_q + 2'h1;
      enc_q      <= enc_d;
      valid_a_q  <= 1'b1;
    end else begin
      valid_a_q <= take_half;
      if (take_half) begin
        rd_q    <= rd_d;
        enc_q   <= enc_d;
        phase_q <= USE_SERIALIZER ? !phase_q : 1'b0;
      end
    end
  end

  // Width of the parallel word towards the serializer
  assign pma_w = (enc_on || SYMBOL10) ? (DOUBLE_WIDTH ? `W_DBL10 : `W_SYM10)
                                      : (DOUBLE_WIDTH ? `W_DBL8 : `W_SYM8);

  // Slip clamped to width minus one
  assign slip_n = !slip_on ? 6'h00 :
                  ({1'b0, TX_SLIP_SEL} > pma_w - 6'h01) ? pma_w - 6'h01
                                                       : {1'b0, TX_SLIP_SEL};

  // Previous and current word side by side
  assign comb = ({20'h00000, enc_q} << pma_w) | {20'h00000, prev_q};

  // Slip stage and output registers
  always @(posedge CLK) begin
    if (RESET) begin
      prev_q       <= {`HALF_W{1'b0}};
      TX_PMA_DATA  <= rst_pat;
      TX_PMA_VALID <= enc_on;
    end else begin
      TX_PMA_VALID <= valid_a_q;
      if (valid_a_q) begin
        prev_q      <= enc_q;
        TX_PMA_DATA <= comb[`HALF_W-1 + (pma_w - slip_n) -: `HALF_W]
                       & ~({`HALF_W{1'b1}} << pma_w);
      end
    end
  end
endmodule // tx_pcs_serializer_encoder

// ===== verilog/tx_pcs_consts.vh
`ifndef TX_PCS_CONSTS_VH
`define TX_PCS_CONSTS_VH

// Datapath widths
`define DATA_W      40
`define K_W         4
`define HALF_W      20
`define LANE_W      10
`define FIFO_DEPTH  4
`define SLIP_SEL_W  5

// Configuration codes on CFG_MODE
`define CFG_PCIE    2'h1
`define CFG_10G     2'h2

// Synchronisation and reset patterns
`define SYNC_COUNT  2'h3
`define K285_BYTE   8'hBC
`define K285_NEG    10'h17C
`define K285_POS    10'h283
`define RD_NEG      1'b0

// Interface widths in bits
`define W_SYM8      6'h08
`define W_SYM10     6'h0A
`define W_DBL8      6'h10
`define W_DBL10     6'h14

`endif

// ===== test/tx_pcs_serializer_encoder_assertions.sv
`include "tx_pcs_consts.vh"
module tx_pcs_checker (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        TX_IN_READY,
  input wire logic [1:0]  CFG_MODE,
  input wire logic [1:0]  TX_FORCEDISP,
  input wire logic        DOUBLE_WIDTH,
  input wire logic        USE_ENCODER,
  input wire logic [19:0] TX_PMA_DATA,
  input wire logic        TX_PMA_VALID,
  input wire logic        SYNC_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Encoder really in use, per width
  wire       enc = USE_ENCODER && CFG_MODE == `CFG_PCIE;
  wire       es  = enc && !DOUBLE_WIDTH;
  wire       ed  = enc && DOUBLE_WIDTH;
  wire [9:0] d0  = TX_PMA_DATA[9:0];
  chk_rst_pattern: assert property ($fell(RESET) && es |->
    d0 == `K285_NEG && TX_PMA_VALID) else $error("no reset pattern");
  chk_ready_release: assert property ($fell(RESET) |-> TX_IN_READY)
    else $error("ready low after release");
  chk_sync_single: assert property ($fell(RESET) && es |-> ##2
    d0 == `K285_NEG ##1 d0 == `K285_POS ##1 d0 == `K285_NEG)
    else $error("bad single sync order");
  chk_sync_double: assert property ($fell(RESET) && ed |-> ##2
    (TX_PMA_DATA == {`K285_POS, `K285_NEG})[*3])
    else $error("bad double sync words");
  chk_done_noenc: assert property (!enc |-> SYNC_DONE
    && !($past(RESET) && TX_PMA_VALID))
    else $error("sync flag low or word valid without encoder");
  chk_sync_count: assert property ($fell(RESET) && enc |-> !SYNC_DONE
    ##1 !SYNC_DONE ##1 !SYNC_DONE ##1 SYNC_DONE)
    else $error("sync flag timing wrong");
  chk_disp_flip: assert property (es && SYNC_DONE && TX_FORCEDISP == 2'h0
    && TX_PMA_VALID && d0 == `K285_NEG ##1 TX_PMA_VALID
    && d0 inside {`K285_NEG, `K285_POS} |-> d0 == `K285_POS)
    else $error("disparity did not flip");
  chk_idle_hold: assert property (!TX_PMA_VALID && !$past(RESET) |->
    $stable(TX_PMA_DATA)) else $error("data moved while idle");
  chk_upper_zero: assert property (!DOUBLE_WIDTH && !$past(DOUBLE_WIDTH)
    |-> TX_PMA_DATA[19:10] == 10'h000) else $error("upper lane not zero");
  // Main scenarios reached
  cover property ($fell(RESET) && ed);
  cover property (es && SYNC_DONE && TX_PMA_VALID);
  cover property (!TX_IN_READY);
endmodule // tx_pcs_checker
bind tx_pcs_serializer_encoder tx_pcs_checker chk (.CLK, .RESET,
  .TX_IN_READY, .CFG_MODE, .TX_FORCEDISP, .DOUBLE_WIDTH, .USE_ENCODER,
  .TX_PMA_DATA, .TX_PMA_VALID, .SYNC_DONE);

// ===== test/fabric_src.sv
`include "tx_pcs_consts.vh"
module fabric_src (
  input  wire logic            clk,
  input  wire logic            ready,
  output logic                 valid,
  output logic [`DATA_W-1:0]   data,
  output logic [`K_W-1:0]      k
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    valid = 1'b0;
    data  = '0;
    k     = '0;
  end
  // Released lines show inverted data, never a stale word
  task automatic idle;
    valid <= 1'b0;
    data  <= ~data;
    k     <= ~k;
  endtask
  // Offer a word after an optional stall, hold it until taken or 64 cycles pass
  task automatic send(input logic [`DATA_W-1:0] w, input logic [`K_W-1:0] kk,
      input int gap, output bit ok);
    int n;
    n = 0;
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge clk);
    end
    valid <= 1'b1;
    data  <= w;
    k     <= kk;
    do begin
      @(posedge clk);
      n++;
    end while (!ready && n < 64);
    ok = ready;
  endtask
endmodule // fabric_src

// ===== test/tx_pcs_serializer_encoder_tb.sv
`include "tx_pcs_consts.vh"
module tx_pcs_serializer_encoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESET, DOUBLE_WIDTH, SYMBOL10;
  logic        USE_SERIALIZER, USE_ENCODER;
  logic [1:0]  CFG_MODE, TX_FORCEDISP, TX_DISPVAL;
  logic [4:0]  TX_SLIP_SEL;
  wire  [39:0] TX_PARALLEL_DATA;
  wire  [3:0]  TX_DATAK;
  wire         TX_IN_VALID, TX_IN_READY, TX_PMA_VALID, SYNC_DONE;
  wire  [19:0] TX_PMA_DATA;
  logic [19:0] got[$];
  int          fails, checks_done, full_seen;

  tx_pcs_serializer_encoder dut (.CLK, .RESET, .TX_PARALLEL_DATA,
    .TX_DATAK, .TX_IN_VALID, .TX_IN_READY, .CFG_MODE, .DOUBLE_WIDTH,
    .SYMBOL10, .USE_SERIALIZER, .USE_ENCODER, .TX_FORCEDISP, .TX_DISPVAL,
    .TX_SLIP_SEL, .TX_PMA_DATA, .TX_PMA_VALID, .SYNC_DONE);
  fabric_src src (.clk(CLK), .ready(TX_IN_READY), .valid(TX_IN_VALID),
    .data(TX_PARALLEL_DATA), .k(TX_DATAK));

  // 125 MHz clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // Collect output words, count refused offers
  always @(posedge CLK) begin
    if (!RESET && TX_PMA_VALID) got.push_back(TX_PMA_DATA);
    if (TX_IN_VALID && !TX_IN_READY) full_seen++;
  end

  task automatic complete_run;
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [19:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  // New mode under a 16-cycle reset
  task automatic setup(input logic [1:0] cfg, input logic dw, s10, ser,
      enc, input logic [4:0] sl, input logic [1:0] fd, dv);
    @(posedge CLK);
    RESET <= 1'b1;
    {CFG_MODE, DOUBLE_WIDTH, SYMBOL10, USE_SERIALIZER, USE_ENCODER,
     TX_SLIP_SEL, TX_FORCEDISP, TX_DISPVAL} <= {cfg, dw, s10, ser, enc, sl,
     fd, dv};
    repeat (16) @(posedge CLK);
    got.delete();
    full_seen = 0;
    RESET <= 1'b0;
  endtask
  task automatic put(input logic [39:0] w, input logic [3:0] kk, input int g);
    bit ok;
    src.send(w, kk, g, ok);
    if (!ok) begin
      fails++;
      $display("unexpected at %0t refused %h %h", $time, w, kk);
    end
  endtask
  // Release input and let the pipe drain
  task automatic done;
    src.idle();
    repeat (40) @(posedge CLK);
  endtask
  task automatic expect_seq(input int off, input logic [19:0] e[$]);
    cmp(20'(got.size()), 20'(off + e.size()));
    foreach (e[i]) cmp(got[off + i], e[i]);
  endtask

  // Unencoded words through or around the serializer
  task automatic t_plain(input logic dw, s10, ser);
    int          hw;
    logic [39:0] w, m;
    logic [19:0] e[$];
    hw = (dw ? 16 : 8) + (s10 ? (dw ? 4 : 2) : 0);
    m = (40'h1 << hw) - 40'h1;
    setup(2'h0, dw, s10, ser, 1'b0, 5'h00, 2'h0, 2'h0);
    for (int i = 0; i < 10; i++) begin
      w = (40'hC3A5965A3C + 40'(i) * 40'h0F1E2D3C4B) & ((m << hw) | m);
      put(w, 4'h0, i == 9 ? 3 : 0);
      e.push_back(20'(w & m));
      if (ser) e.push_back(20'((w >> hw) & m));
    end
    done();
    expect_seq(0, e);
    if (ser) cmp(20'(full_seen > 0), 20'h00001);
  endtask
  // Encoded single width: sync groups, then K and D groups
  task automatic t_enc1;
    setup(`CFG_PCIE, 1'b0, 1'b0, 1'b1, 1'b1, 5'h00, 2'h0, 2'h0);
    put(40'h00BC, 4'h1, 0);
    put(40'hBCBC, 4'h3, 0);
    done();
    expect_seq(2, '{20'h17C, 20'h283, 20'h17C, 20'h283, 20'h0B9, 20'h17C,
      20'h283});
  endtask
  // Forced disparity keeps every group after the sync groups in one column
  task automatic t_force(input logic dv);
    logic [19:0] k5;
    k5 = dv ? 20'h283 : 20'h17C;
    setup(`CFG_PCIE, 1'b0, 1'b0, 1'b1, 1'b1, 5'h05, 2'h1, {1'b0, dv});
    put(40'hBCBC, 4'h3, 0);
    put(40'hBCBC, 4'h3, 0);
    done();
    expect_seq(2, '{20'h17C, 20'h283, 20'h17C, k5, k5, k5, k5});
  endtask
  // Double width: two lanes, disparity chained lane to lane
  task automatic t_enc2;
    setup(`CFG_PCIE, 1'b1, 1'b0, 1'b1, 1'b1, 5'h00, 2'h0, 2'h0);
    put(40'hBCBC00BC, 4'hD, 0);
    done();
    expect_seq(2, '{{10'h283, 10'h17C}, {10'h283, 10'h17C},
      {10'h283, 10'h17C}, {10'h346, 10'h17C}, {10'h17C, 10'h283}});
  endtask
  // Encoder request outside PCIe mode leaves words raw
  task automatic t_gate;
    setup(`CFG_10G, 1'b0, 1'b1, 1'b0, 1'b1, 5'h00, 2'h0, 2'h0);
    put(40'h00BC, 4'h1, 0);
    done();
    expect_seq(0, '{20'h000BC});
  endtask
  // Slip delays the stream by the clamped bit count
  task automatic t_slip(input logic [4:0] n);
    logic [9:0] w[3];
    int         s;
    w = '{10'h2D5, 10'h13A, 10'h3C6};
    s = n > 9 ? 9 : n;
    setup(`CFG_10G, 1'b0, 1'b1, 1'b0, 1'b0, n, 2'h0, 2'h0);
    foreach (w[i]) put({30'h0, w[i]}, 4'h0, 0);
    done();
    for (int i = 1; i < 3; i++)
      cmp(got[i], 20'(({w[i], w[i-1]} >> (10 - s)) & 20'h003FF));
  endtask

  // Main sequence
  initial begin
    RESET = 1'b1;
    {CFG_MODE, DOUBLE_WIDTH, SYMBOL10, USE_SERIALIZER, USE_ENCODER,
     TX_SLIP_SEL, TX_FORCEDISP, TX_DISPVAL} = '0;
    t_plain(1'b0, 1'b0, 1'b1);
    t_plain(1'b0, 1'b1, 1'b1);
    t_plain(1'b1, 1'b0, 1'b1);
    t_plain(1'b1, 1'b1, 1'b1);
    t_plain(1'b0, 1'b1, 1'b0);
    t_enc1();
    t_force(1'b0);
    t_force(1'b1);
    t_enc2();
    t_gate();
    t_slip(5'h03);
    t_slip(5'h09);
    t_slip(5'h19);
    complete_run();
  end
  // Watchdog, far beyond the expected run
  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule // tx_pcs_serializer_encoder_tb
